//--- src/smp_pkg.sv
`default_nettype none
package smp_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [2:0] SMP_IDX_KEY = 3'h0;
  localparam logic [2:0] SMP_IDX_FLAGS = 3'h2;
  localparam logic [2:0] SMP_IDX_BORDERS = 3'h4;
  localparam logic [2:0] SMP_IDX_RIGHTS = 3'h6;

  // Reset values.
  localparam logic [15:0] SMP_KEY_READ = 16'h9600;
  localparam logic [15:0] SMP_BORDERS_RST = 16'h0000;
  localparam logic [15:0] SMP_RIGHTS_RST = 16'h7777;
  localparam logic [3:0] SMP_FLAGS_RST = 4'h0;

  // Key byte that opens register writes.
  localparam logic [7:0] SMP_ACCESS_KEY = 8'hA5;

  // Field layout of the border register; other bits read as zero.
  localparam int SMP_UPPER_LSB = 8;
  localparam int SMP_LOWER_LSB = 0;
  localparam int SMP_BORDER_W = 5;
  localparam logic [15:0] SMP_BORDERS_MASK = 16'h1F1F;

  // Nibble layout of the rights register, one nibble per region.
  localparam int SMP_BIT_READ = 0;
  localparam int SMP_BIT_WRITE = 1;
  localparam int SMP_BIT_EXEC = 2;
  localparam int SMP_BIT_RESET = 3;

  // Region numbers: flag bit and rights nibble share the index.
  localparam int SMP_REG_SEG1 = 0;
  localparam int SMP_REG_SEG2 = 1;
  localparam int SMP_REG_SEG3 = 2;
  localparam int SMP_REG_INFO = 3;
  localparam int SMP_REGIONS = 4;

  // Kinds of core access.
  localparam logic [1:0] SMP_KIND_READ = 2'h0;
  localparam logic [1:0] SMP_KIND_WRITE = 2'h1;
  localparam logic [1:0] SMP_KIND_EXEC = 2'h2;

  localparam int SMP_ADDR_W = 16;

  // One memory access of the processor core.
  typedef struct packed {
    logic valid;
    logic [1:0] kind;
    logic [SMP_ADDR_W-1:0] addr;
  } smp_access_s;

endpackage : smp_pkg
`default_nettype wire

//--- src/smp_viol_flag.sv
`timescale 1ns/1ns
`default_nettype none
module smp_viol_flag
  import smp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic set_i,
  input wire logic sw_wr_i,
  input wire logic sw_bit_i,
  input wire logic vec_clr_i,
  output logic flag_o
);

  logic flag_reg;
  logic flag_next;

  // A new violation wins over any clear in the same cycle.
  assign flag_next = set_i ? 1'b1 :
                     (sw_wr_i && !sw_bit_i) ? 1'b0 :
                     vec_clr_i ? 1'b0 : flag_reg;

  // Sticky flag storage.
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag_o = flag_reg;

  property p_flag_set;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      set_i |=> flag_o;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("Flag not set on violation.");

  property p_sw_clear;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      sw_wr_i && !sw_bit_i && !set_i |=> !flag_o;
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("Zero write did not clear flag.");

  property p_one_keeps;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      sw_wr_i && sw_bit_i && !vec_clr_i |=> flag_o == $past(flag_o) || $past(set_i);
  endproperty
  a_one_keeps: assert property (p_one_keeps) else $error("One write changed flag.");

  property p_vec_clear;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      vec_clr_i && !set_i && !sw_wr_i |=> !flag_o;
  endproperty
  a_vec_clear: assert property (p_vec_clear) else $error("Vector read did not clear flag.");

endmodule : smp_viol_flag
`default_nettype wire

//--- src/smp_region_check.sv
`timescale 1ns/1ns
`default_nettype none
module smp_region_check
  import smp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic hit_i,
  input wire logic [1:0] kind_i,
  input wire logic [3:0] rights_i,
  output logic viol_o
);

  logic viol_reg;
  logic xe;
  logic we;
  logic re;
  logic bad_exec;
  logic bad_write;
  logic bad_read;
  logic viol_now;

  assign xe = rights_i[SMP_BIT_EXEC];
  assign we = rights_i[SMP_BIT_WRITE];
  assign re = rights_i[SMP_BIT_READ];

  // A read faults only when the region allows none of read, write and execute.
  assign bad_exec = (kind_i == SMP_KIND_EXEC) && !xe;
  assign bad_write = (kind_i == SMP_KIND_WRITE) && !we;
  assign bad_read = (kind_i == SMP_KIND_READ) && !re && !we && !xe;
  assign viol_now = hit_i && (bad_exec || bad_write || bad_read);

  // One-cycle violation pulse, one edge after the access.
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      viol_reg <= 1'b0;
    end else begin
      viol_reg <= viol_now;
    end
  end

  assign viol_o = viol_reg;

  property p_exec_viol;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      hit_i && kind_i == SMP_KIND_EXEC && !xe |=> viol_o;
  endproperty
  a_exec_viol: assert property (p_exec_viol) else $error("Execute fault missed.");

  property p_read_allowed;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      hit_i && kind_i == SMP_KIND_READ && (we || xe) |=> !viol_o;
  endproperty
  a_read_allowed: assert property (p_read_allowed) else $error("Read faulted wrongly.");

  property p_write_viol;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      hit_i && kind_i == SMP_KIND_WRITE && !we |=> viol_o;
  endproperty
  a_write_viol: assert property (p_write_viol) else $error("Write fault missed.");

endmodule : smp_region_check
`default_nettype wire

//--- src/smp_top.sv
`timescale 1ns/1ns
`default_nettype none
module smp_top
  import smp_pkg::*;
#(
  parameter logic [SMP_ADDR_W-1:0] INFO_BASE = 16'h1800,
  parameter logic [SMP_ADDR_W-1:0] INFO_LAST = 16'h19FF,
  parameter logic [SMP_ADDR_W-1:0] MAIN_BASE = 16'hC200,
  parameter logic [SMP_ADDR_W-1:0] MAIN_LAST = 16'hFFFF,
  parameter int BORDER_SHIFT = 11
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [2:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire smp_access_s acc_i,
  input wire logic rcv_read_i,
  output logic viol_o,
  output logic puc_req_o
);

  if (BORDER_SHIFT + SMP_BORDER_W > SMP_ADDR_W || BORDER_SHIFT < 0) begin : g_chk
    $error("BORDER_SHIFT does not fit the address width.");
  end

  logic wait_reg;
  logic [31:0] rdata_reg;
  logic unlock_reg;
  logic [15:0] borders_reg;
  logic [15:0] borders_next;
  logic [15:0] rights_reg;
  logic [15:0] rights_next;
  logic viol_any_reg;
  logic puc_reg;
  logic [3:0] flags;
  logic [3:0] viol;
  logic [3:0] hit;

  // Bus decode: a request completes at the edge where waitrequest is low.
  wire req = avs_read_i || avs_write_i;
  wire wr_fire = avs_write_i && !wait_reg;
  wire [15:0] wmask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  wire sel_key = avs_address_i == SMP_IDX_KEY;
  wire sel_flags = avs_address_i == SMP_IDX_FLAGS;
  wire sel_borders = avs_address_i == SMP_IDX_BORDERS;
  wire sel_rights = avs_address_i == SMP_IDX_RIGHTS;
  wire sel_prot = sel_flags || sel_borders || sel_rights;

  // Key handling: the right key opens writes, a wrong key byte closes them.
  wire key_wr = wr_fire && sel_key && avs_byteenable_i[1];
  wire key_ok = avs_writedata_i[15:8] == SMP_ACCESS_KEY;
  wire key_word = avs_byteenable_i[1] && avs_byteenable_i[0];
  wire prot_wr = wr_fire && sel_prot && unlock_reg;
  wire key_fault = (key_wr && !key_ok && key_word) || (wr_fire && sel_prot && !unlock_reg);

  // Read multiplexer; unused bits and unmapped addresses read zero.
  wire [15:0] rd_mux = sel_key ? SMP_KEY_READ :
                       sel_flags ? {12'h000, flags} :
                       sel_borders ? borders_reg :
                       sel_rights ? rights_reg : 16'h0000;

  // Byte-masked writes; border bits outside the fields stay zero.
  assign borders_next = (borders_reg & ~wmask) |
                        (avs_writedata_i[15:0] & wmask & SMP_BORDERS_MASK);
  assign rights_next = (rights_reg & ~wmask) | (avs_writedata_i[15:0] & wmask);

  // Bus handshake: one wait cycle, then one cycle with waitrequest low.
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wait_reg <= !(req && wait_reg);
      if (req && wait_reg) begin
        rdata_reg <= {16'h0000, rd_mux};
      end
    end
  end

  // Write permission state from the key register.
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      unlock_reg <= 1'b0;
    end else if (key_wr) begin
      unlock_reg <= key_ok;
    end
  end

  // Border and rights registers; brownout reset restores the defaults.
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      borders_reg <= SMP_BORDERS_RST;
      rights_reg <= SMP_RIGHTS_RST;
    end else begin
      if (prot_wr && sel_borders) begin
        borders_reg <= borders_next;
      end
      if (prot_wr && sel_rights) begin
        rights_reg <= rights_next;
      end
    end
  end

  // Border addresses derived from the two fields.
  wire [SMP_BORDER_W-1:0] upper_border_field = borders_reg[SMP_UPPER_LSB +: SMP_BORDER_W];
  wire [SMP_BORDER_W-1:0] lower_border_field = borders_reg[SMP_LOWER_LSB +: SMP_BORDER_W];
  wire [SMP_ADDR_W-1:0] hi_addr = SMP_ADDR_W'({11'h000, upper_border_field} << BORDER_SHIFT);
  wire [SMP_ADDR_W-1:0] lo_addr = SMP_ADDR_W'({11'h000, lower_border_field} << BORDER_SHIFT);

  // Segment sorting: at or above the upper border is segment 3, then 2, then 1.
  wire in_main = acc_i.valid && acc_i.addr >= MAIN_BASE && acc_i.addr <= MAIN_LAST;
  wire in_info = acc_i.valid && acc_i.addr >= INFO_BASE && acc_i.addr <= INFO_LAST;
  wire above_hi = acc_i.addr >= hi_addr;
  wire above_lo = acc_i.addr >= lo_addr;
  assign hit[SMP_REG_INFO] = in_info;
  assign hit[SMP_REG_SEG3] = in_main && above_hi;
  assign hit[SMP_REG_SEG2] = in_main && !above_hi && above_lo;
  assign hit[SMP_REG_SEG1] = in_main && !above_hi && !above_lo;

  // Vector read clears only the highest pending flag, info first.
  wire [3:0] vec_clr;
  assign vec_clr[3] = rcv_read_i && flags[3];
  assign vec_clr[2] = rcv_read_i && !flags[3] && flags[2];
  assign vec_clr[1] = rcv_read_i && !flags[3] && !flags[2] && flags[1];
  assign vec_clr[0] = rcv_read_i && (flags[3:1] == 3'h0) && flags[0];

  // One checker and one sticky flag per region.
  wire [3:0] reset_sel;
  for (genvar k = 0; k < SMP_REGIONS; k++) begin : g_region
    assign reset_sel[k] = rights_reg[4 * k + SMP_BIT_RESET];
    smp_region_check u_check (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .hit_i(hit[k]),
      .kind_i(acc_i.kind),
      .rights_i(rights_reg[4*k +: 4]),
      .viol_o(viol[k])
    );
    smp_viol_flag u_flag (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .set_i(viol[k]),
      .sw_wr_i(prot_wr && sel_flags && avs_byteenable_i[0]),
      .sw_bit_i(avs_writedata_i[k]),
      .vec_clr_i(vec_clr[k]),
      .flag_o(flags[k])
    );
  end

  // Selected violations and key faults request a power-up-clear reset.
  wire puc_now = |(viol & reset_sel) || key_fault;

  // Registered event outputs.
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      viol_any_reg <= 1'b0;
      puc_reg <= 1'b0;
    end else begin
      viol_any_reg <= |viol;
      puc_reg <= puc_now;
    end
  end

  assign avs_readdata_o = rdata_reg;
  assign avs_waitrequest_o = wait_reg;
  assign viol_o = viol_any_reg;
  assign puc_req_o = puc_reg;

  property p_flags_reserved;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      avs_read_i && !avs_waitrequest_o && sel_flags |-> avs_readdata_o[31:4] == 28'h0;
  endproperty
  a_flags_reserved: assert property (p_flags_reserved) else $error("Flag bits 15-4 not zero.");

  property p_borders_reserved;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (borders_reg & ~SMP_BORDERS_MASK) == 16'h0000;
  endproperty
  a_borders_reserved: assert property (p_borders_reserved) else $error("Border reserved bit set.");

  property p_all_seg3;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      borders_reg == 16'h0000 && in_main |-> hit[SMP_REG_SEG3] && hit[1:0] == 2'h0;
  endproperty
  a_all_seg3: assert property (p_all_seg3) else $error("Zero borders not all segment 3.");

  property p_locked_write;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      wr_fire && sel_borders && !unlock_reg |=> $stable(borders_reg) && puc_req_o;
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("Locked write took effect.");

  property p_puc_on_viol;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      viol[SMP_REG_SEG3] && reset_sel[SMP_REG_SEG3] |=> puc_req_o;
  endproperty
  a_puc_on_viol: assert property (p_puc_on_viol) else $error("No reset on selected fault.");

  property p_puc_pulse;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      puc_req_o |-> $past(|viol) || $past(wr_fire && (sel_prot || sel_key));
  endproperty
  a_puc_pulse: assert property (p_puc_pulse) else $error("Reset request without cause.");

  property p_vec_lower_kept;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      rcv_read_i && flags[3] && flags[0] && !(prot_wr && sel_flags) |=> flags[0];
  endproperty
  a_vec_lower_kept: assert property (p_vec_lower_kept) else $error("Lower flag lost on vector.");

  property p_border_write;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      prot_wr && sel_borders && avs_byteenable_i[1:0] == 2'h3
      |=> borders_reg == ($past(avs_writedata_i[15:0]) & SMP_BORDERS_MASK);
  endproperty
  a_border_write: assert property (p_border_write) else $error("Border write wrong.");

  property p_upper_field;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      prot_wr && sel_borders && avs_byteenable_i[1]
      |=> upper_border_field == $past(avs_writedata_i[SMP_UPPER_LSB +: SMP_BORDER_W]);
  endproperty
  a_upper_field: assert property (p_upper_field) else $error("Upper border wrong.");

  property p_lower_field;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      prot_wr && sel_borders && avs_byteenable_i[0]
      |=> lower_border_field == $past(avs_writedata_i[SMP_LOWER_LSB +: SMP_BORDER_W]);
  endproperty
  a_lower_field: assert property (p_lower_field) else $error("Lower border wrong.");

  property p_flags_locked;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      wr_fire && sel_flags && !unlock_reg && viol == 4'h0 && !rcv_read_i
      |=> $stable(flags) && puc_req_o;
  endproperty
  a_flags_locked: assert property (p_flags_locked) else $error("Locked flag write acted.");

  property p_key_open;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      key_wr && key_ok |=> unlock_reg;
  endproperty
  a_key_open: assert property (p_key_open) else $error("Right key did not open.");

  property p_bad_key;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      key_wr && !key_ok && key_word |=> puc_req_o && !unlock_reg;
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("Bad key word missed.");

  property p_rights_write;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      prot_wr && sel_rights && avs_byteenable_i[1:0] == 2'h3
      |=> rights_reg == $past(avs_writedata_i[15:0]);
  endproperty
  a_rights_write: assert property (p_rights_write) else $error("Rights write wrong.");

  property p_vec_top_clear;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      rcv_read_i && flags[SMP_REG_INFO] && !viol[SMP_REG_INFO] |=> !flags[SMP_REG_INFO];
  endproperty
  a_vec_top_clear: assert property (p_vec_top_clear) else $error("Top flag kept.");

  property p_viol_out;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      viol != 4'h0 |=> viol_o;
  endproperty
  a_viol_out: assert property (p_viol_out) else $error("Violation not reported.");

  property p_flag_only;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      viol != 4'h0 && (viol & reset_sel) == 4'h0 && !key_fault |=> !puc_req_o;
  endproperty
  a_flag_only: assert property (p_flag_only) else $error("Reset on flag-only fault.");

  property p_unmapped_read;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      avs_read_i && !avs_waitrequest_o && !sel_key && !sel_prot
      |-> avs_readdata_o == 32'h0000_0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("Unmapped read not zero.");

endmodule : smp_top
`default_nettype wire

//--- sim/smp_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module smp_core_model
  import smp_pkg::*;
(
  input wire logic core_clk_i,
  output var smp_access_s acc_o
);
  logic go = 1'b0;
  logic [1:0] cmd_kind = 2'h0;
  logic [15:0] cmd_addr = 16'h0000;

  // Drives one access per cycle while go is up; idle cycles scramble the fields.
  always @(posedge core_clk_i) begin
    if (go) begin
      acc_o <= '{valid: 1'b1, kind: cmd_kind, addr: cmd_addr};
    end else begin
      acc_o <= '{valid: 1'b0, kind: ~cmd_kind, addr: ~cmd_addr};
    end
  end

  // Issues n identical back-to-back accesses; call just after a rising edge.
  task automatic run(input logic [1:0] k, input logic [15:0] a, input int n);
    cmd_kind <= k;
    cmd_addr <= a;
    go <= 1'b1;
    repeat (n) @(posedge core_clk_i);
    go <= 1'b0;
  endtask : run
endmodule : smp_core_model
`default_nettype wire

//--- sim/test_smp_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module test_smp_top
  import smp_pkg::*;
;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [2:0] adr = 3'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'h0;
  logic rcv = 1'b0;
  logic [31:0] rdata;
  logic wait_o;
  logic viol;
  logic power_up_clear_reset;
  smp_access_s acc;
  int fails = 0;
  int checks_done = 0;
  int viol_n = 0;
  int puc_n = 0;

  // Clock and pulse counters on the two event outputs.
  always #4 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    if (viol === 1'b1) viol_n++;
    if (power_up_clear_reset === 1'b1) puc_n++;
  end

  smp_top u_smp_top (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o), .acc_i(acc), .rcv_read_i(rcv),
    .viol_o(viol), .puc_req_o(power_up_clear_reset));
  smp_core_model u_smp_core_model (.core_clk_i(core_clk_i), .acc_o(acc));

  // One bus access; holds the request until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [2:0] a, input logic [15:0] d,
                     input logic [3:0] e, output logic [15:0] q);
    adr <= a;
    rd <= !w;
    wr <= w;
    wd <= {16'h0000, d};
    be <= e;
    @(posedge core_clk_i);
    while (wait_o !== 1'b0) begin
      @(posedge core_clk_i);
    end
    q = rdata[15:0];
    if (!w) `CHK(rdata[31:16], 16'h0000)
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge core_clk_i);
  endtask : bus

  task automatic wr16(input logic [2:0] a, input logic [15:0] d, input logic [3:0] e);
    logic [15:0] q;
    bus(1'b1, a, d, e, q);
  endtask : wr16

  task automatic rd_chk(input logic [2:0] a, input logic [15:0] x);
    logic [15:0] q;
    bus(1'b0, a, 16'h0000, 4'hF, q);
    `CHK(q, x)
  endtask : rd_chk

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : idle

  // One core access followed by enough cycles for flag and reset request.
  task automatic hit(input logic [1:0] k, input logic [15:0] a);
    u_smp_core_model.run(k, a, 1);
    idle(4);
  endtask : hit

  function automatic logic [15:0] addr_of(input int r);
    case (r)
      0: addr_of = 16'hC400;
      1: addr_of = 16'hD000;
      2: addr_of = 16'hF000;
      default: addr_of = 16'h1880;
    endcase
  endfunction : addr_of

  function automatic logic [15:0] rights(input int r, input logic [3:0] nib);
    rights = (16'h7777 & ~(16'h000F << (4 * r))) | ({12'h000, nib} << (4 * r));
  endfunction : rights

  task automatic t_reset();
    rd_chk(SMP_IDX_KEY, 16'h9600);
    rd_chk(SMP_IDX_FLAGS, 16'h0000);
    rd_chk(SMP_IDX_BORDERS, 16'h0000);
    rd_chk(SMP_IDX_RIGHTS, 16'h7777);
    rd_chk(3'h1, 16'h0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_lock();
    int p;
    p = puc_n;
    wr16(SMP_IDX_BORDERS, 16'h1F1F, 4'h3);
    idle(3);
    `CHK(puc_n, p + 1)
    rd_chk(SMP_IDX_BORDERS, 16'h0000);
    wr16(SMP_IDX_KEY, 16'hA500, 4'h3);
    wr16(SMP_IDX_BORDERS, 16'hFFFF, 4'h3);
    rd_chk(SMP_IDX_BORDERS, 16'h1F1F);
    wr16(SMP_IDX_KEY, 16'h1200, 4'h2);
    wr16(SMP_IDX_BORDERS, 16'h0000, 4'h3);
    wr16(SMP_IDX_KEY, 16'h1200, 4'h3);
    idle(3);
    `CHK(puc_n, p + 3)
    rd_chk(SMP_IDX_BORDERS, 16'h1F1F);
    wr16(SMP_IDX_KEY, 16'hA500, 4'h2);
    wr16(3'h5, 16'hFFFF, 4'h3);
    rd_chk(3'h5, 16'h0000);
    wr16(SMP_IDX_BORDERS, 16'h1C19, 4'h3);
    rd_chk(SMP_IDX_BORDERS, 16'h1C19);
    $display("test lock done");
  endtask : t_lock

  task automatic t_access(input int r, input logic [1:0] k, input logic [3:0] nib, input int ev);
    int v;
    int p;
    wr16(SMP_IDX_RIGHTS, rights(r, nib), 4'h3);
    wr16(SMP_IDX_FLAGS, 16'h0000, 4'h3);
    v = viol_n;
    p = puc_n;
    hit(k, addr_of(r));
    `CHK(viol_n, v + ev)
    `CHK(puc_n, p + ev * int'(nib[3]))
    rd_chk(SMP_IDX_FLAGS, (ev != 0) ? (16'h0001 << r) : 16'h0000);
  endtask : t_access

  task automatic t_rights();
    for (int r = 0; r < SMP_REGIONS; r++) begin
      t_access(r, SMP_KIND_EXEC, 4'h3, 1);
      t_access(r, SMP_KIND_WRITE, 4'h5, 1);
      t_access(r, SMP_KIND_READ, 4'h0, 1);
      t_access(r, SMP_KIND_READ, 4'h6, 0);
      t_access(r, SMP_KIND_EXEC, 4'h7, 0);
      t_access(r, SMP_KIND_EXEC, 4'hB, 1);
    end
    $display("test rights done");
  endtask : t_rights

  task automatic t_priority();
    int v;
    wr16(SMP_IDX_RIGHTS, 16'h3333, 4'h3);
    wr16(SMP_IDX_FLAGS, 16'h0000, 4'h3);
    for (int r = 0; r < SMP_REGIONS; r++) hit(SMP_KIND_EXEC, addr_of(r));
    rd_chk(SMP_IDX_FLAGS, 16'h000F);
    wr16(SMP_IDX_FLAGS, 16'h0008, 4'h3);
    rd_chk(SMP_IDX_FLAGS, 16'h0008);
    hit(SMP_KIND_EXEC, addr_of(2));
    hit(SMP_KIND_EXEC, addr_of(1));
    rcv <= 1'b1;
    idle(1);
    rcv <= 1'b0;
    idle(1);
    rd_chk(SMP_IDX_FLAGS, 16'h0006);
    rcv <= 1'b1;
    idle(1);
    rcv <= 1'b0;
    idle(1);
    rd_chk(SMP_IDX_FLAGS, 16'h0002);
    v = viol_n;
    u_smp_core_model.run(SMP_KIND_EXEC, addr_of(0), 3);
    idle(4);
    `CHK(viol_n, v + 3)
    rd_chk(SMP_IDX_FLAGS, 16'h0003);
    $display("test priority done");
  endtask : t_priority

  task automatic t_brownout();
    int p;
    sys_rst_i <= 1'b1;
    idle(8);
    sys_rst_i <= 1'b0;
    idle(1);
    rd_chk(SMP_IDX_BORDERS, 16'h0000);
    rd_chk(SMP_IDX_RIGHTS, 16'h7777);
    rd_chk(SMP_IDX_FLAGS, 16'h0000);
    wr16(SMP_IDX_KEY, 16'hA500, 4'h3);
    wr16(SMP_IDX_RIGHTS, 16'h7377, 4'h3);
    hit(SMP_KIND_EXEC, addr_of(0));
    rd_chk(SMP_IDX_FLAGS, 16'h0004);
    wr16(SMP_IDX_KEY, 16'h1200, 4'h2);
    p = puc_n;
    wr16(SMP_IDX_FLAGS, 16'h0000, 4'h3);
    idle(3);
    `CHK(puc_n, p + 1)
    rd_chk(SMP_IDX_FLAGS, 16'h0004);
    $display("test brownout done");
  endtask : t_brownout

  task automatic results();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  // Main sequence after the initial reset.
  initial begin
    idle(8);
    sys_rst_i <= 1'b0;
    idle(1);
    t_reset();
    t_lock();
    t_rights();
    t_priority();
    t_brownout();
    results();
  end

  // Watchdog against a hang anywhere in the sequence.
  initial begin
    idle(20000);
    fails++;
    results();
  end
endmodule : test_smp_top
`default_nettype wire
